// file: src/csr_pkg.sv
/*
 * Constants for the CPU status, register file and data map block.
 * Assumes a single clock domain and a synchronous active-high reset.
 */
package csr_pkg;
    // =========================================================
    // Status register bit positions
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned FLAG_T = 6;
    localparam int unsigned FLAG_I = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // =========================================================
    // Data space map (byte addresses)
    localparam logic [15:0] MAP_REG_BASE = 16'h0000;
    localparam logic [15:0] MAP_IO_BASE = 16'h0020;
    localparam logic [15:0] MAP_EXT_BASE = 16'h0060;
    localparam logic [15:0] MAP_SRAM_BASE = 16'h0100;
    localparam logic [15:0] MAP_END = 16'h0500;
    localparam logic [5:0] DISP_MAX = 6'h3F;
    // =========================================================
    // Register bus offsets
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_SP_LO = 4'h1;
    localparam logic [3:0] OFS_SP_HI = 4'h2;
    localparam logic [3:0] OFS_PC_LO = 4'h3;
    localparam logic [3:0] OFS_PC_HI = 4'h4;
    localparam logic [3:0] OFS_CORE_STATE = 4'h5;
    // =========================================================
    // Timing counts in clock cycles
    localparam logic [2:0] IRQ_ENTRY_CYC = 3'h4;
    localparam logic [2:0] WAKE_EXTRA_CYC = 3'h4;
    localparam logic [2:0] IRQ_RETURN_CYC = 3'h4;
    localparam logic [2:0] JUMP_CYC = 3'h3;
    localparam logic [2:0] SRAM_CYC = 3'h2;
    localparam logic [15:0] SP_RESET = 16'h0000;
    // =========================================================
    // Operations
    typedef enum logic [3:0] {
        OP_NONE = 4'h0, OP_ADD = 4'h1, OP_ADC = 4'h2, OP_SUB = 4'h3,
        OP_AND = 4'h4, OP_OR = 4'h5, OP_XOR = 4'h6, OP_ADIW = 4'h7,
        OP_MOVW = 4'h8, OP_MUL = 4'h9
    } csr_alu_e;
    typedef enum logic [1:0] {
        REGION_REG = 2'h0, REGION_IO = 2'h1, REGION_EXT = 2'h2, REGION_SRAM = 2'h3
    } csr_region_e;
    typedef enum logic [1:0] {
        PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2
    } csr_ptr_e;
    typedef enum logic [1:0] {
        AM_PLAIN = 2'h0, AM_PREDEC = 2'h1, AM_POSTINC = 2'h2, AM_DISP = 2'h3
    } csr_amode_e;
endpackage

// file: src/csr_core.sv
/*
 * CPU support logic: interrupt entry and return sequencing, status flags,
 * 32 x 8 working registers with pointer pairs, data address decode and
 * SRAM access timing, program counter.
 * Assumes the instruction decoder drives one-cycle request strobes, only
 * when core_ready is high, and that inputs are synchronous to clk_sys.
 */
// Local design decisions: the register offsets and the plain strobed port.
module csr_core
    import csr_pkg::*;
#(
    parameter int unsigned PC_WIDTH = 13
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register bus
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Instruction requests
    input wire logic irq_req,
    input wire logic [PC_WIDTH-1:0] irq_vector,
    input wire logic sleeping,
    input wire logic instr_done,
    input wire logic irq_return_instr,
    input wire logic irq_on_instr,
    input wire logic irq_off_instr,
    input wire logic jump_req,
    input wire logic [PC_WIDTH-1:0] jump_target,
    input wire logic bit_store_instr,
    input wire logic bit_load_instr,
    input wire logic [2:0] bit_sel,
    // Register file ports
    input wire logic [4:0] rd_addr,
    input wire logic [4:0] rr_addr,
    input wire csr_alu_e alu_op,
    input wire logic [7:0] alu_imm,
    // Data access
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_short_io,
    input wire logic mem_indirect,
    input wire csr_ptr_e mem_ptr,
    input wire csr_amode_e mem_amode,
    input wire logic [5:0] mem_disp,
    input wire logic [15:0] mem_direct_addr,
    input wire logic [7:0] mem_wdata,
    // Outputs
    output logic [7:0] processor_status_flags,
    output logic [PC_WIDTH-1:0] program_counter,
    output logic [15:0] stack_ptr,
    output logic core_ready,
    output logic irq_ack,
    output logic [15:0] data_addr,
    output csr_region_e data_region,
    output logic data_strobe,
    output logic data_we,
    output logic [7:0] data_wdata,
    output logic data_fault,
    output logic [7:0] rf_rdata
);
    if (PC_WIDTH < 9 || PC_WIDTH > 16) begin : g_bad_width
        $error("PC_WIDTH must be 9..16");
    end

    // =========================================================
    // Sequencer
    typedef enum logic [5:0] {
        ST_RUN = 6'b000001, ST_WAKE = 6'b000010, ST_ENTRY = 6'b000100,
        ST_RETURN = 6'b001000, ST_JUMP = 6'b010000, ST_MEM = 6'b100000
    } csr_state_e;
    csr_state_e state;
    csr_state_e next_state;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic hold_one;
    logic [7:0] rf [32];
    logic [PC_WIDTH-1:0] ret_pc;
    logic [15:0] mem_addr_q;
    logic mem_we_q;

    // Register values come in as arguments so that continuous assignments see every change
    function automatic logic [15:0] pair(input logic [7:0] hi, input logic [7:0] lo);
        return {hi, lo};
    endfunction

    // Interrupt may be taken: enabled, idle core, not right after return
    // global enable gate
    wire irq_ok = irq_req && processor_status_flags[FLAG_I] && !hold_one;
    wire take_irq = irq_ok && state == ST_RUN && instr_done;
    wire take_wake = irq_ok && state == ST_RUN && sleeping && !instr_done;
    wire take_ret = irq_return_instr && state == ST_RUN && !take_irq;
    wire take_jump = jump_req && state == ST_RUN && !take_irq && !take_ret;
    wire cnt_last = cnt == 3'h1;

    // =========================================================
    // Data address decode
    wire [4:0] ptr_lo = 5'd26 + {2'b00, mem_ptr, 1'b0};
    wire [15:0] ptr_val = pair(rf[ptr_lo + 5'd1], rf[ptr_lo]);
    // displacement on Y or Z only
    wire disp_ok = mem_ptr != PTR_X && mem_disp <= DISP_MAX;
    wire [15:0] ind_addr = mem_amode == AM_PREDEC ? ptr_val - 16'h0001 :
                           mem_amode == AM_DISP ? ptr_val + {10'h000, mem_disp} : ptr_val;
    wire [15:0] eff_addr = mem_indirect ? ind_addr :
                           mem_short_io ? mem_direct_addr + MAP_IO_BASE : mem_direct_addr;
    wire csr_region_e region = eff_addr < MAP_IO_BASE ? REGION_REG :
                               eff_addr < MAP_EXT_BASE ? REGION_IO :
                               eff_addr < MAP_SRAM_BASE ? REGION_EXT : REGION_SRAM;
    // short I/O cannot reach extended space
    wire bad_access = (mem_short_io && region != REGION_IO) || eff_addr >= MAP_END ||
                      (mem_indirect && mem_amode == AM_DISP && !disp_ok);
    wire take_mem = mem_req && state == ST_RUN && !take_irq && !take_ret && !take_jump;
    wire mem_go = take_mem && !bad_access;
    // register file visible at lowest addresses
    wire rf_hit = mem_go && region == REGION_REG;
    wire ptr_upd = mem_go && mem_indirect && (mem_amode == AM_PREDEC || mem_amode == AM_POSTINC);
    wire [15:0] ptr_new = mem_amode == AM_PREDEC ? ind_addr : ptr_val + 16'h0001;

    // =========================================================
    // ALU and flags
    wire [7:0] op_a = rf[rd_addr];
    wire [7:0] op_b = alu_op == OP_ADIW ? alu_imm : rf[rr_addr];
    wire [15:0] word_a = pair(rf[rd_addr + 5'd1], rf[rd_addr]);
    logic [8:0] res8;
    logic [16:0] res16;
    logic wide;
    logic next_h;
    logic next_v;
    always_comb begin
        res8 = 9'h000;
        res16 = 17'h00000;
        wide = 1'b0;
        next_h = processor_status_flags[FLAG_H];
        next_v = 1'b0;
        unique case (alu_op)
            // two 8-bit reads, one 8-bit write-back
            OP_ADD, OP_ADC: begin
                res8 = {1'b0, op_a} + {1'b0, op_b} +
                       {8'h00, alu_op == OP_ADC && processor_status_flags[FLAG_C]};
                next_h = (op_a[3] & op_b[3]) | (op_b[3] & ~res8[3]) | (~res8[3] & op_a[3]);
                next_v = (op_a[7] & op_b[7] & ~res8[7]) | (~op_a[7] & ~op_b[7] & res8[7]);
            end
            OP_SUB: begin
                res8 = {1'b0, op_a} - {1'b0, op_b};
                next_h = (~op_a[3] & op_b[3]) | (op_b[3] & res8[3]) | (res8[3] & ~op_a[3]);
                next_v = (op_a[7] & ~op_b[7] & ~res8[7]) | (~op_a[7] & op_b[7] & res8[7]);
            end
            OP_AND: res8 = {1'b0, op_a & op_b};
            OP_OR: res8 = {1'b0, op_a | op_b};
            OP_XOR: res8 = {1'b0, op_a ^ op_b};
            OP_ADIW: begin
                wide = 1'b1;
                res16 = {1'b0, word_a} + {11'h000, alu_imm[5:0]};
                next_v = ~word_a[15] & res16[15];
            end
            // two 8-bit reads with 16-bit write-back
            OP_MOVW: begin
                wide = 1'b1;
                res16 = {1'b0, pair(rf[rr_addr + 5'd1], rf[rr_addr])};
            end
            OP_MUL: begin
                wide = 1'b1;
                res16 = {1'b0, 16'(op_a) * 16'(op_b)};
            end
            default: ;
        endcase
    end
    wire alu_go = alu_op != OP_NONE && state == ST_RUN;
    wire [4:0] wide_dst = alu_op == OP_MUL ? 5'd0 : rd_addr;
    wire res_n = wide ? res16[15] : res8[7];
    wire res_z = wide ? res16[15:0] == 16'h0000 : res8[7:0] == 8'h00;
    wire res_c = alu_op == OP_MUL ? res16[15] : wide ? res16[16] : res8[8];

    logic [7:0] next_status;
    always_comb begin
        next_status = processor_status_flags;
        if (alu_go && alu_op != OP_MOVW) begin
            next_status[FLAG_C] = res_c;
            next_status[FLAG_Z] = res_z;
            next_status[FLAG_N] = res_n;
            next_status[FLAG_V] = next_v;
            next_status[FLAG_S] = res_n ^ next_v;
            next_status[FLAG_H] = next_h;
        end
        if (bit_store_instr && state == ST_RUN) next_status[FLAG_T] = op_a[bit_sel];
        if (irq_on_instr && state == ST_RUN) next_status[FLAG_I] = 1'b1;
        if (irq_off_instr) next_status[FLAG_I] = 1'b0;
        // hardware clear on entry, set on return
        if (take_irq || take_wake) next_status[FLAG_I] = 1'b0;
        if (state == ST_RETURN && cnt_last) next_status[FLAG_I] = 1'b1;
        if (reg_wr && reg_addr == OFS_STATUS) next_status = reg_wdata;
    end

    // =========================================================
    // Sequencer next state
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        unique case (state)
            ST_RUN: begin
                if (take_wake) begin
                    next_state = ST_WAKE;
                    next_cnt = WAKE_EXTRA_CYC;
                end else if (take_irq) begin
                    next_state = ST_ENTRY;
                    next_cnt = IRQ_ENTRY_CYC;
                end else if (take_ret) begin
                    next_state = ST_RETURN;
                    next_cnt = IRQ_RETURN_CYC;
                end else if (take_jump) begin
                    next_state = ST_JUMP;
                    next_cnt = JUMP_CYC;
                end else if (mem_go && region == REGION_SRAM) begin
                    next_state = ST_MEM;
                    next_cnt = SRAM_CYC;
                end
            end
            ST_WAKE: begin
                next_cnt = cnt - 3'h1;
                if (cnt_last) begin
                    next_state = ST_ENTRY;
                    next_cnt = IRQ_ENTRY_CYC;
                end
            end
            ST_ENTRY, ST_RETURN, ST_JUMP, ST_MEM: begin
                next_cnt = cnt - 3'h1;
                if (cnt_last) next_state = ST_RUN;
            end
        endcase
    end

    // =========================================================
    // Sequential state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= ST_RUN;
            cnt <= 3'h0;
            hold_one <= 1'b0;
            ret_pc <= '0;
            irq_ack <= 1'b0;
            mem_addr_q <= 16'h0000;
            mem_we_q <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            irq_ack <= take_irq || take_wake;
            if (take_irq || take_wake) ret_pc <= program_counter;
            if (take_mem) mem_addr_q <= eff_addr;
            if (take_mem) mem_we_q <= mem_we;
            if (state == ST_RETURN && cnt_last) hold_one <= 1'b1;
            else if (instr_done) hold_one <= 1'b0;
        end
    end

    // no save or restore on entry and return
    always_ff @(posedge clk_sys) begin
        if (rst) processor_status_flags <= STATUS_RESET;
        else processor_status_flags <= next_status;
    end

    // =========================================================
    // Program counter and stack pointer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            program_counter <= '0;
            stack_ptr <= SP_RESET;
        end else begin
            if (state == ST_RUN && instr_done && !take_irq) begin
                program_counter <= program_counter + 1'b1;
            end
            if (state == ST_ENTRY && cnt_last) program_counter <= irq_vector;
            if (state == ST_JUMP && cnt_last) program_counter <= jump_target;
            if (state == ST_ENTRY && cnt == IRQ_ENTRY_CYC) stack_ptr <= stack_ptr - 16'h0002;
            if (state == ST_RETURN && cnt_last) begin
                stack_ptr <= stack_ptr + 16'h0002;
                program_counter <= ret_pc;
            end
            if (reg_wr && reg_addr == OFS_SP_LO) stack_ptr[7:0] <= reg_wdata;
            if (reg_wr && reg_addr == OFS_SP_HI) stack_ptr[15:8] <= reg_wdata;
        end
    end

    // =========================================================
    // Register file
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < 32; i++) rf[i] <= 8'h00;
        end else begin
            if (alu_go && wide) begin
                rf[wide_dst] <= res16[7:0];
                rf[wide_dst + 5'd1] <= res16[15:8];
            end else if (alu_go && alu_op != OP_NONE) begin
                rf[rd_addr] <= res8[7:0];
            end
            if (bit_load_instr && state == ST_RUN) rf[rd_addr][bit_sel] <= processor_status_flags[FLAG_T];
            if (rf_hit && mem_we) rf[eff_addr[4:0]] <= mem_wdata;
            if (ptr_upd) begin
                rf[ptr_lo] <= ptr_new[7:0];
                rf[ptr_lo + 5'd1] <= ptr_new[15:8];
            end
        end
    end

    // =========================================================
    // Data port and register bus
    wire [7:0] bus_mux = reg_addr == OFS_STATUS ? processor_status_flags :
                         reg_addr == OFS_SP_LO ? stack_ptr[7:0] :
                         reg_addr == OFS_SP_HI ? stack_ptr[15:8] :
                         reg_addr == OFS_PC_LO ? program_counter[7:0] :
                         reg_addr == OFS_PC_HI ? 8'(program_counter >> 8) :
                         reg_addr == OFS_CORE_STATE ? {2'b00, state} : 8'h00;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            core_ready <= 1'b0;
            data_addr <= 16'h0000;
            data_region <= REGION_REG;
            data_strobe <= 1'b0;
            data_we <= 1'b0;
            data_wdata <= 8'h00;
            data_fault <= 1'b0;
            rf_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? bus_mux : 8'h00;
            core_ready <= next_state == ST_RUN;
            data_strobe <= mem_go && region != REGION_REG;
            data_fault <= take_mem && bad_access;
            data_we <= mem_go && mem_we;
            if (take_mem) begin
                data_addr <= eff_addr;
                data_region <= region;
                data_wdata <= mem_wdata;
            end
            if (rf_hit) rf_rdata <= rf[eff_addr[4:0]];
        end
    end
endmodule

// file: verification/csr_core_properties.sv
/*
 * Checker for the CPU status, register file and data map block.
 * Bound to csr_core and sees only its ports, on the single clk_sys domain.
 */
module csr_core_properties
    import csr_pkg::*;
#(
    parameter int unsigned PC_WIDTH = 13
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Requests
    input wire logic reg_wr,
    input wire logic irq_req,
    input wire logic [PC_WIDTH-1:0] irq_vector,
    input wire logic instr_done,
    input wire logic irq_return_instr,
    input wire logic jump_req,
    input wire logic [PC_WIDTH-1:0] jump_target,
    input wire csr_alu_e alu_op,
    input wire logic mem_req,
    input wire logic mem_short_io,
    input wire logic mem_indirect,
    input wire logic [15:0] mem_direct_addr,
    // Results
    input wire logic [7:0] processor_status_flags,
    input wire logic [PC_WIDTH-1:0] program_counter,
    input wire logic [15:0] stack_ptr,
    input wire logic core_ready,
    input wire logic irq_ack,
    input wire logic [15:0] data_addr,
    input wire csr_region_e data_region,
    input wire logic data_strobe,
    input wire logic data_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // =========================================================
    // Helpers
    wire logic [7:0] sf = processor_status_flags;
    wire logic irq_win = irq_req && sf[FLAG_I] && instr_done;
    wire csr_region_e exp_region = (data_addr < MAP_IO_BASE) ? REGION_REG :
        (data_addr < MAP_EXT_BASE) ? REGION_IO :
        (data_addr < MAP_SRAM_BASE) ? REGION_EXT : REGION_SRAM;
    sequence s_vector_reached;
        ##4 program_counter == $past(irq_vector, 5);
    endsequence
    sequence s_return_done;
        ##5 sf[FLAG_I] && stack_ptr == $past(stack_ptr, 5) + 16'h0002;
    endsequence
    // =========================================================
    // Properties
    a_reset_clear: assert property ($past(rst) |-> sf == STATUS_RESET)
        else $error("status not clear after reset");
    a_irq_gate: assert property (!sf[FLAG_I] |=> !irq_ack)
        else $error("interrupt taken while disabled");
    a_ack_clears_enable: assert property (irq_ack |-> !sf[FLAG_I])
        else $error("enable still set on interrupt take");
    a_entry_stack_drop: assert property (irq_ack && $past(instr_done)
        |=> stack_ptr == $past(stack_ptr) - 16'h0002)
        else $error("stack not lowered by two on entry");
    a_entry_vector: assert property (irq_ack && $past(instr_done) |-> s_vector_reached)
        else $error("vector not reached after entry");
    a_return_seq: assert property (irq_return_instr && core_ready && !irq_win && !reg_wr
        |-> s_return_done)
        else $error("return did not restore stack and enable");
    a_jump_three: assert property (jump_req && core_ready && !irq_win
        && !irq_return_instr |-> ##4 program_counter == $past(jump_target, 4))
        else $error("jump target not reached in three cycles");
    a_sign_flag: assert property ($past(alu_op != OP_NONE && core_ready && !reg_wr)
        |-> sf[FLAG_S] == (sf[FLAG_N] ^ sf[FLAG_V]))
        else $error("sign flag differs from negative xor overflow");
    a_region_map: assert property (data_strobe
        |-> data_region == exp_region && data_region != REGION_REG)
        else $error("data region decode wrong");
    a_short_io_fault: assert property (mem_req && core_ready && mem_short_io
        && mem_direct_addr > 16'h003F |=> data_fault && !data_strobe)
        else $error("short io beyond range not refused");
    a_top_fault: assert property (mem_req && core_ready && !mem_indirect && !mem_short_io
        && mem_direct_addr >= MAP_END |=> data_fault)
        else $error("access beyond data space not refused");
endmodule

// file: verification/test_csr_core.sv
/*
 * Self-checking testbench for csr_core with random stimulus from a fixed seed.
 * Assumes the checker module is compiled before this file.
 */
module test_csr_core
    import csr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PC_WIDTH = 13;
    logic clk_sys, rst, reg_wr, reg_rd, irq_req, sleeping, mem_we, mem_short_io, mem_indirect;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, alu_imm, mem_wdata, strb, reg_rdata, processor_status_flags;
    logic [7:0] data_wdata, rf_rdata, sv;
    logic [PC_WIDTH-1:0] irq_vector, jump_target, program_counter;
    logic [2:0] bit_sel;
    logic [4:0] rd_addr, rr_addr;
    logic [5:0] mem_disp;
    logic [15:0] mem_direct_addr, stack_ptr, data_addr;
    logic core_ready, irq_ack, data_strobe, data_we, data_fault, st, ft, wt;
    csr_alu_e alu_op;
    csr_ptr_e mem_ptr;
    csr_amode_e mem_amode;
    csr_region_e data_region;
    int error_cnt, total_checks, seed, i, n, lo;
    logic [15:0] tbl [8] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060,
        16'h00FF, 16'h0100, 16'h04FF, 16'h0500};
    wire irq_return_instr = strb[0];
    wire irq_on_instr = strb[1];
    wire irq_off_instr = strb[2];
    wire jump_req = strb[3];
    wire instr_done = strb[4];
    wire mem_req = strb[5];
    wire bit_store_instr = strb[6];
    wire bit_load_instr = strb[7];
    csr_core #(.PC_WIDTH(PC_WIDTH)) csr_core_inst (.*);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // =========================================================
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic rdy();
        for (n = 0; n < 20 && core_ready !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
    endtask
    task automatic pulse(input int b);
        @(posedge clk_sys) strb[b] <= 1'b1;
        @(posedge clk_sys) strb[b] <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk_sys) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys) reg_rd <= 1'b0;
        #1 chk(16'(reg_rdata), 16'(exp));
    endtask
    task automatic acc(input logic [15:0] adr, input logic sio);
        rdy();
        {mem_direct_addr, mem_short_io} <= {adr, sio};
        {mem_we, mem_wdata} <= 9'($random(seed));
        pulse(5);
        {st, ft, wt, lo} = '0;
        repeat (4) begin
            #1 {st, ft, wt} = {st | data_strobe, ft | data_fault, wt | data_we};
            lo += int'(!core_ready);
            @(posedge clk_sys);
        end
    endtask
    function automatic csr_region_e region_of(input logic [15:0] ad);
        if (ad < MAP_IO_BASE) return REGION_REG;
        if (ad < MAP_EXT_BASE) return REGION_IO;
        if (ad < MAP_SRAM_BASE) return REGION_EXT;
        return REGION_SRAM;
    endfunction
    // =========================================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        end_sim();
    end
    // =========================================================
    // Main sequence
    initial begin
        {seed, error_cnt, total_checks} = {32'h0E81, 64'h0};
        {rst, reg_wr, reg_rd, irq_req, sleeping, mem_we, mem_short_io, mem_indirect} = 8'h80;
        {reg_addr, reg_wdata, alu_imm, mem_wdata, strb, irq_vector, jump_target} = '0;
        {bit_sel, rd_addr, rr_addr, mem_disp, mem_direct_addr} = '0;
        alu_op = OP_NONE;
        mem_ptr = PTR_X;
        mem_amode = AM_PLAIN;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rd(OFS_STATUS, STATUS_RESET);
        rd(4'hF, 8'h00);
        for (i = 0; i < 4; i++) begin
            sv = 8'($random(seed));
            wr(OFS_STATUS, sv);
            rd(OFS_STATUS, sv);
        end
        wr(OFS_STATUS, 8'h00);
        wr(OFS_SP_LO, 8'hFF);
        wr(OFS_SP_HI, 8'h04);
        rd(OFS_SP_HI, 8'h04);
        irq_vector <= PC_WIDTH'($random(seed));
        irq_req <= 1'b1;
        pulse(4);
        n = 0;
        repeat (8) @(posedge clk_sys) n += int'(irq_ack === 1'b1);
        chk(16'(n), 16'h0000);
        wr(OFS_STATUS, 8'hAA);
        pulse(4);
        #1 chk(16'(irq_ack), 16'h0001);
        chk(16'(processor_status_flags), 16'h002A);
        @(posedge clk_sys);
        #1 chk(stack_ptr, 16'h04FD);
        irq_req <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 chk(16'(program_counter), 16'(irq_vector));
        wr(OFS_STATUS, 8'h15);
        pulse(0);
        repeat (4) @(posedge clk_sys);
        #1 chk(16'(processor_status_flags), 16'h0095);
        chk(stack_ptr, 16'h04FF);
        pulse(2);
        #1 chk(16'(processor_status_flags[FLAG_I]), 16'h0000);
        pulse(1);
        #1 chk(16'(processor_status_flags[FLAG_I]), 16'h0001);
        pulse(2);
        for (i = 0; i < 3; i++) begin
            rdy();
            jump_target <= PC_WIDTH'($random(seed));
            pulse(3);
            repeat (3) @(posedge clk_sys);
            #1 chk(16'(program_counter), 16'(jump_target));
        end
        pulse(4);
        wr(OFS_STATUS, 8'h80);
        {sleeping, irq_req} <= 2'b11;
        @(posedge clk_sys) {sleeping, irq_req} <= 2'b00;
        #1 chk(16'(irq_ack), 16'h0001);
        repeat (7) @(posedge clk_sys);
        #1 chk(16'(core_ready), 16'h0000);
        @(posedge clk_sys);
        #1 chk(16'(program_counter), 16'(irq_vector));
        for (i = 0; i < 25; i++) begin
            rdy();
            @(posedge clk_sys) {rd_addr, rr_addr, alu_imm} <= 18'($random(seed));
            alu_op <= (i == 24) ? OP_XOR : csr_alu_e'(4'h1 + 4'($unsigned($random(seed)) % 9));
            if (i == 24) {rd_addr, rr_addr} <= {5'h05, 5'h05};
            @(posedge clk_sys) alu_op <= OP_NONE;
            #1 sv = processor_status_flags;
            chk(16'(sv[FLAG_S]), 16'(sv[FLAG_N] ^ sv[FLAG_V]));
        end
        chk(16'(sv[4:1]), 16'h0001);
        wr(OFS_STATUS, 8'h40);
        bit_sel <= 3'($random(seed));
        pulse(6);
        #1 chk(16'(processor_status_flags[FLAG_T]), 16'h0000);
        wr(OFS_STATUS, 8'h40);
        pulse(7);
        acc(16'h0005, 1'b0);
        chk(16'(rf_rdata), 16'(8'h01 << bit_sel));
        for (i = 0; i < 8; i++) begin
            acc(tbl[i], 1'b0);
            chk(16'(st), 16'(tbl[i] >= MAP_IO_BASE && tbl[i] < MAP_END));
            chk(16'(ft), 16'(tbl[i] >= MAP_END));
            if (st === 1'b1) chk(16'(data_region), 16'(region_of(tbl[i])));
            if (tbl[i] >= MAP_SRAM_BASE && tbl[i] < MAP_END) chk(16'(lo), 16'h0002);
        end
        acc(16'h003F, 1'b1);
        chk(data_addr, 16'h005F);
        chk(16'({wt, data_wdata}), 16'({mem_we, mem_wdata}));
        acc(16'h0040, 1'b1);
        chk(16'({ft, st}), 16'h0002);
        end_sim();
    end
endmodule
bind csr_core csr_core_properties #(.PC_WIDTH(PC_WIDTH)) csr_core_properties_inst (.*);
